// *** rtl/pbus_pkg.sv ***
// shared constants and carriers for the parallel bus slave port
// Summary of operation
// - bus runs eight or four data lines, always five control lines.
// - command/data select high means command or status, low means data.
// - bus select is active low; strobes ignored while it is high.
// - data rides on port B, driven only in reads; interrupt on port A bit 4.
// - interrupt is an output; select, strobes and command/data are inputs.
// - select and strobe patterns decode command write, status read, data moves.
// - command register is written by host, read only by internal logic.
// - status register is host readable only; host writes never touch it.
// - device raises interrupt on a request; host then polls status.
// - read data stays stable on the lines for at least 300 ns.
// - before standby, port A wakeup lines are inputs and their levels latched.
// - with wakeup enabled, any port A change from the latch ends standby.
// - data and buffer paths write one register; reads pick buffer or pins.
package pbus_pkg;
    localparam int CLK_MHZ = 100;
    localparam int DATA_OUT_NS = 300;
    localparam int DATA_OUT_CYC = (DATA_OUT_NS * CLK_MHZ + 999) / 1000;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int DW = 8;
    localparam int NIB = 4;
    localparam int HOLD_W = 6;
    localparam int CD_BIT = 0;
    localparam int CS_BIT = 1;
    localparam int RD_BIT = 2;
    localparam int WR_BIT = 3;
    localparam int INT_BIT = 4;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] DIR_ALL_OUT = 8'hFF;

    typedef enum logic [1:0] {ACC_NONE, ACC_CMD_WR, ACC_STAT_RD,
        ACC_DATA_X} acc_kind_t;

    typedef enum {ST_IDLE, ST_WRITE, ST_READ, ST_RECOVER} bus_state_t;

    // one completed host write byte and its command flag
    typedef struct packed {
        logic is_cmd;
        logic [7:0] value;
    } host_word_t;
endpackage

// *** rtl/pbus_fifo.sv ***
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module pbus_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full_n;
    } fifo_state_t;

    fifo_state_t st_reg, st_next;
    logic push, pop;

    assign in_ready = st_reg.full_n;
    assign out_valid = (st_reg.cnt != '0);
    assign out_data = st_reg.mem[st_reg.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (pop)
            st_next.rp = st_reg.rp + 1'b1;
        st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // ready comes from a flop, not from a compare on the count
        st_next.full_n = (st_next.cnt != DEPTH[AW:0]);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '{mem: '0, wp: '0, rp: '0, cnt: '0, full_n: 1'b1};
        else
            st_reg <= st_next;
    end

    chk_no_overflow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.cnt == DEPTH[AW:0] && !out_ready
        |=> st_reg.cnt == DEPTH[AW:0] && $stable(st_reg.wp))
        else $error("write taken while fifo full");
endmodule

// *** rtl/pbus_slave.sv ***
// parallel bus slave: decode, status, command, data fifo, key wakeup
`timescale 1ns/100ps
module pbus_slave (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic nibble_mode,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe_n,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe_n,
    output logic [7:0] command_out,
    output logic command_stb,
    input wire logic [7:0] status_in,
    input wire logic request_set,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic wake_enable,
    input wire logic standby_req,
    output logic in_standby,
    output logic wake_pulse,
    input wire logic port_path_wr,
    input wire logic [7:0] port_path_data,
    input wire logic port_read_pins,
    output logic [7:0] port_read_data
);
    typedef struct packed {
        pbus_pkg::bus_state_t st;
        pbus_pkg::acc_kind_t kind;
        logic is_cmd;
        logic hi_done;
        logic [7:0] shift;
        logic [pbus_pkg::HOLD_W-1:0] hold;
        logic [7:0] drive;
        logic drive_en;
        logic irq;
        logic pend;
        logic [7:0] cmd;
        logic cmd_stb;
        logic [7:0] rx;
        logic rx_v;
        logic tx_pop;
        logic [7:0] port_buf;
        logic [7:0] wake_latch;
        logic stby;
        logic wake;
        logic [7:0] rd_out;
    } top_state_t;

    top_state_t s_reg, s_next;
    logic rst_n;
    logic [1:0] rst_sync_reg;
    logic sel_n, cd, rd_n, wr_n;
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [7:0] read_src;

    // released reset; asynchronous assert, two-stage release
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        // kept out of s_reg: its reset is the raw pin, not rst_n
        if (!nrst)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    assign cd = port_a_in[pbus_pkg::CD_BIT];
    assign sel_n = port_a_in[pbus_pkg::CS_BIT];
    assign rd_n = port_a_in[pbus_pkg::RD_BIT];
    assign wr_n = port_a_in[pbus_pkg::WR_BIT];

    // device-to-host data is buffered until the host reads it
    pbus_fifo #(
        .WIDTH(pbus_pkg::DW),
        .DEPTH(pbus_pkg::FIFO_DEPTH),
        .AW(pbus_pkg::FIFO_AW)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(s_reg.tx_pop)
    );
    assign tx_ready = fifo_in_ready;

    // empty fifo reads back as zero
    assign read_src = (s_reg.kind == pbus_pkg::ACC_STAT_RD) ? status_in
        : (fifo_out_valid ? fifo_out_data : pbus_pkg::BYTE_ZERO);

    always_comb
    begin
        s_next = s_reg;
        s_next.cmd_stb = 1'b0;
        s_next.tx_pop = 1'b0;
        s_next.wake = 1'b0;
        if (s_reg.rx_v && rx_ready)
            s_next.rx_v = 1'b0;
        if (s_reg.hold != '0)
            s_next.hold = s_reg.hold - 1'b1;

        case (s_reg.st)
            pbus_pkg::ST_IDLE:
            begin
                s_next.drive_en = 1'b0;
                // strobes mean nothing while select is high
                if (!sel_n)
                begin
                    if (!wr_n && rd_n)
                    begin
                        s_next.st = pbus_pkg::ST_WRITE;
                        s_next.is_cmd = cd;
                        s_next.kind = cd ? pbus_pkg::ACC_CMD_WR
                            : pbus_pkg::ACC_DATA_X;
                    end
                    else if (wr_n && !rd_n)
                    begin
                        s_next.st = pbus_pkg::ST_READ;
                        s_next.kind = cd ? pbus_pkg::ACC_STAT_RD
                            : pbus_pkg::ACC_DATA_X;
                        s_next.hold =
                            pbus_pkg::DATA_OUT_CYC[pbus_pkg::HOLD_W-1:0];
                    end
                end
            end
            pbus_pkg::ST_WRITE:
            begin
                // sample on the rising edge of the write strobe
                if (wr_n || sel_n)
                begin
                    s_next.st = pbus_pkg::ST_RECOVER;
                    if (nibble_mode && !s_reg.hi_done)
                    begin
                        s_next.shift = {port_b_in[3:0], 4'h0};
                        s_next.hi_done = 1'b1;
                    end
                    else
                    begin
                        s_next.shift = nibble_mode
                            ? {s_reg.shift[7:4], port_b_in[3:0]} : port_b_in;
                        s_next.hi_done = 1'b0;
                        if (s_reg.is_cmd)
                        begin
                            s_next.cmd = s_next.shift;
                            s_next.cmd_stb = 1'b1;
                        end
                        else
                        begin
                            s_next.rx = s_next.shift;
                            s_next.rx_v = 1'b1;
                        end
                    end
                end
            end
            pbus_pkg::ST_READ:
            begin
                s_next.drive_en = 1'b1;
                // high nibble first in four-line mode
                if (nibble_mode && !s_reg.hi_done)
                    s_next.drive = {4'h0, read_src[7:4]};
                else if (nibble_mode)
                    s_next.drive = {4'h0, read_src[3:0]};
                else
                    s_next.drive = read_src;
                // data held at least the minimum even if strobe is short
                if ((rd_n || sel_n) && s_reg.hold == '0)
                begin
                    s_next.st = pbus_pkg::ST_RECOVER;
                    s_next.drive_en = 1'b0;
                    if (nibble_mode && !s_reg.hi_done)
                        s_next.hi_done = 1'b1;
                    else
                    begin
                        s_next.hi_done = 1'b0;
                        if (s_reg.kind == pbus_pkg::ACC_STAT_RD)
                        begin
                            s_next.pend = 1'b0;
                            s_next.irq = 1'b0;
                        end
                        else if (fifo_out_valid)
                            s_next.tx_pop = 1'b1;
                    end
                end
            end
            pbus_pkg::ST_RECOVER:
            begin
                s_next.drive_en = 1'b0;
                if (wr_n && rd_n)
                    s_next.st = pbus_pkg::ST_IDLE;
            end
            default:
                s_next.st = pbus_pkg::ST_IDLE;
        endcase

        // a new request wins over the clear by a status read
        if (request_set)
        begin
            s_next.pend = 1'b1;
            s_next.irq = 1'b1;
        end
        else if (s_next.pend)
            s_next.irq = 1'b1;

        // both port write paths land in one register
        if (port_path_wr)
            s_next.port_buf = port_path_data;
        s_next.rd_out = port_read_pins ? port_a_in : s_reg.port_buf;

        // latching happens on the way into standby
        if (standby_req && !s_reg.stby)
        begin
            s_next.wake_latch = port_a_in;
            s_next.stby = 1'b1;
        end
        else if (s_reg.stby && wake_enable && port_a_in != s_reg.wake_latch)
        begin
            s_next.stby = 1'b0;
            s_next.wake = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg.st <= pbus_pkg::ST_IDLE;
            s_reg.kind <= pbus_pkg::ACC_NONE;
            s_reg.is_cmd <= 1'b0;
            s_reg.hi_done <= 1'b0;
            s_reg.shift <= pbus_pkg::BYTE_ZERO;
            s_reg.hold <= '0;
            s_reg.drive <= pbus_pkg::BYTE_ZERO;
            s_reg.drive_en <= 1'b0;
            s_reg.irq <= 1'b0;
            s_reg.pend <= 1'b0;
            s_reg.cmd <= pbus_pkg::BYTE_ZERO;
            s_reg.cmd_stb <= 1'b0;
            s_reg.rx <= pbus_pkg::BYTE_ZERO;
            s_reg.rx_v <= 1'b0;
            s_reg.tx_pop <= 1'b0;
            s_reg.port_buf <= pbus_pkg::BYTE_ZERO;
            s_reg.wake_latch <= pbus_pkg::BYTE_ZERO;
            s_reg.stby <= 1'b0;
            s_reg.wake <= 1'b0;
            s_reg.rd_out <= pbus_pkg::BYTE_ZERO;
        end
        else
        begin
            s_reg.st <= s_next.st;
            s_reg.kind <= s_next.kind;
            s_reg.is_cmd <= s_next.is_cmd;
            s_reg.hi_done <= s_next.hi_done;
            s_reg.shift <= s_next.shift;
            s_reg.hold <= s_next.hold;
            s_reg.drive <= s_next.drive;
            s_reg.drive_en <= s_next.drive_en;
            s_reg.irq <= s_next.irq;
            s_reg.pend <= s_next.pend;
            s_reg.cmd <= s_next.cmd;
            s_reg.cmd_stb <= s_next.cmd_stb;
            s_reg.rx <= s_next.rx;
            s_reg.rx_v <= s_next.rx_v;
            s_reg.tx_pop <= s_next.tx_pop;
            s_reg.port_buf <= s_next.port_buf;
            s_reg.wake_latch <= s_next.wake_latch;
            s_reg.stby <= s_next.stby;
            s_reg.wake <= s_next.wake;
            s_reg.rd_out <= s_next.rd_out;
        end
    end

    // port a: only the interrupt bit is ever driven
    assign port_a_out = 8'(s_reg.irq) << pbus_pkg::INT_BIT;
    assign port_a_oe_n = ~(8'h01 << pbus_pkg::INT_BIT);
    assign port_b_out = s_reg.drive;
    assign port_b_oe_n = {8{~s_reg.drive_en}};
    assign command_out = s_reg.cmd;
    assign command_stb = s_reg.cmd_stb;
    assign rx_data = s_reg.rx;
    assign rx_valid = s_reg.rx_v;
    assign in_standby = s_reg.stby;
    assign wake_pulse = s_reg.wake;
    assign port_read_data = s_reg.rd_out;

    sequence read_begins;
        s_reg.st == pbus_pkg::ST_IDLE && !sel_n && wr_n && !rd_n;
    endsequence

    sequence write_begins;
        s_reg.st == pbus_pkg::ST_IDLE && !sel_n && !wr_n && rd_n;
    endsequence

    // last half of a status read, strobe gone and hold time spent
    sequence status_read_ends;
        s_reg.st == pbus_pkg::ST_READ && s_reg.kind == pbus_pkg::ACC_STAT_RD
        && (rd_n || sel_n) && s_reg.hold == '0
        && !(nibble_mode && !s_reg.hi_done);
    endsequence

    chk_read_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        read_begins |=> (s_reg.st == pbus_pkg::ST_READ) [*8])
        else $error("read data released too early");
    chk_idle_select: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_reg.st == pbus_pkg::ST_IDLE && sel_n
        |=> s_reg.st == pbus_pkg::ST_IDLE)
        else $error("access taken with select high");
    chk_write_decode: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        write_begins
        |=> s_reg.st == pbus_pkg::ST_WRITE && s_reg.is_cmd == $past(cd))
        else $error("write decode wrong");
    chk_drive_only_read: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_reg.drive_en |-> $past(s_reg.st) == pbus_pkg::ST_READ)
        else $error("port b driven outside a read");
    chk_irq_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        request_set |=> s_reg.irq)
        else $error("request did not raise interrupt");
    chk_irq_sticky: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_reg.irq && !(s_reg.st == pbus_pkg::ST_READ
        && s_reg.kind == pbus_pkg::ACC_STAT_RD) |=> s_reg.irq)
        else $error("interrupt dropped without status read");
    chk_irq_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        status_read_ends ##0 !request_set |=> !s_reg.irq)
        else $error("interrupt kept after status read");
    chk_cmd_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_reg.cmd_stb || !$stable(s_reg.cmd)
        |-> s_reg.cmd_stb && $past(s_reg.st) == pbus_pkg::ST_WRITE
        && $past(s_reg.is_cmd))
        else $error("command changed outside command write");
    chk_wake_exit: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_reg.stby && wake_enable && port_a_in != s_reg.wake_latch
        && !standby_req |=> !s_reg.stby && s_reg.wake)
        else $error("wakeup missed");
    chk_port_path: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        port_path_wr ##1 !port_read_pins
        |=> port_read_data == $past(s_reg.port_buf))
        else $error("buffer read path wrong");
endmodule

// *** tb/pbus_host_model.sv ***
// host processor model driving the strobed bus from its gpio pins
`timescale 1ns/100ps
module pbus_host_model (
    input wire logic ref_clk,
    input wire logic [3:0] keys,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe_n,
    output logic [7:0] port_a_in,
    output logic [7:0] port_b_in
);
    logic [3:0] ctl = 4'hF;
    logic [7:0] drv = 8'h00;
    logic [7:0] last = 8'h00;
    logic drv_on = 1'b0;
    assign port_a_in = {keys, ctl};
    // released lines show the inverse of the last byte, not a stale copy
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            port_b_in[i] = !port_b_oe_n[i] ? port_b_out[i]
                : (drv_on ? drv[i] : !last[i]);
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic raw(input logic [3:0] c, input int n);
        ctl = c;
        cyc(n);
    endtask
    task automatic access(input logic cd, input logic rd,
        input logic [7:0] wd, output logic [7:0] rdv, output logic ok);
        int n;
        ok = 1'b1;
        rdv = 8'h00;
        cyc(1);
        ctl[0] = cd;
        cyc(10);
        ctl[1] = 1'b0;
        cyc(10);
        drv = wd;
        drv_on = !rd;
        ctl[rd ? 2 : 3] = 1'b0;
        if (rd)
        begin
            n = 0;
            while (port_b_oe_n[0] !== 1'b0 && n < 20)
            begin
                cyc(1);
                n++;
            end
            ok = (n < 20);
            rdv = port_b_in;
            repeat (30)
            begin
                cyc(1);
                if (port_b_in !== rdv) ok = 1'b0;
            end
        end
        else
            cyc(10);
        ctl[3:2] = 2'b11;
        cyc(10);
        ctl[1] = 1'b1;
        cyc(10);
        last = drv;
        drv_on = 1'b0;
    endtask
    // nibble mode sends the high half first, same flag on both halves
    task automatic xfer(input logic cd, input logic rd, input logic nib,
        input logic [7:0] wd, output logic [7:0] rdv, output logic ok);
        logic [7:0] h;
        logic ok1;
        if (nib)
        begin
            access(cd, rd, {4'h0, wd[7:4]}, h, ok1);
            access(cd, rd, {4'h0, wd[3:0]}, rdv, ok);
            rdv = {h[3:0], rdv[3:0]};
            ok = ok & ok1;
        end
        else
            access(cd, rd, wd, rdv, ok);
    endtask
endmodule

// *** tb/pbus_slave_tb.sv ***
// self-checking bench for the parallel bus slave port
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module pbus_slave_tb;
    typedef struct packed {logic nib; logic cd; logic rd; logic [7:0] v;} row_t;
    row_t rows [8] = '{{1'b0, 1'b1, 1'b0, 8'hA5}, {1'b0, 1'b0, 1'b0, 8'h3C},
        {1'b0, 1'b1, 1'b1, 8'h5A}, {1'b0, 1'b0, 1'b1, 8'hC3},
        {1'b1, 1'b1, 1'b0, 8'h96}, {1'b1, 1'b0, 1'b0, 8'hE1},
        {1'b1, 1'b1, 1'b1, 8'h7E}, {1'b1, 1'b0, 1'b1, 8'h18}};
    logic ref_clk = 1'b0, nrst = 1'b0, nibble_mode = 1'b0, request_set = 1'b0;
    logic [7:0] port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out;
    logic [7:0] port_b_oe_n, command_out, status_in = 8'h00, rx_data;
    logic [7:0] tx_data = 8'h00, port_path_data = 8'h00, port_read_data;
    logic [7:0] rdv, rx_got = 8'h00;
    logic [3:0] keys = 4'h0;
    logic command_stb, tx_valid = 1'b0, tx_ready, rx_valid, rx_ready = 1'b1;
    logic wake_enable = 1'b0, standby_req = 1'b0, in_standby, wake_pulse;
    logic port_path_wr = 1'b0, port_read_pins = 1'b0, ok, woke = 1'b0;
    int num_errors = 0, tests_run = 0, cmd_cnt = 0, cyc_cnt = 0, n, c0;
    always #5 ref_clk = ~ref_clk;
    pbus_host_model i_pbus_host_model (.ref_clk(ref_clk), .keys(keys),
        .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
        .port_a_in(port_a_in), .port_b_in(port_b_in));
    pbus_slave i_pbus_slave (.ref_clk(ref_clk), .nrst(nrst),
        .nibble_mode(nibble_mode), .port_a_in(port_a_in),
        .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
        .port_b_in(port_b_in), .port_b_out(port_b_out),
        .port_b_oe_n(port_b_oe_n), .command_out(command_out),
        .command_stb(command_stb), .status_in(status_in),
        .request_set(request_set), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .wake_enable(wake_enable),
        .standby_req(standby_req), .in_standby(in_standby),
        .wake_pulse(wake_pulse), .port_path_wr(port_path_wr),
        .port_path_data(port_path_data), .port_read_pins(port_read_pins),
        .port_read_data(port_read_data));
    always @(posedge ref_clk)
    begin
        cyc_cnt++;
        if (command_stb === 1'b1) cmd_cnt++;
        if (rx_valid === 1'b1) rx_got <= rx_data;
        if (wake_pulse === 1'b1) woke <= 1'b1;
        // whole run is well under this; a hang ends here
        if (cyc_cnt == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic push(input logic [7:0] v);
        @(negedge ref_clk);
        tx_data = v;
        tx_valid = 1'b1;
        @(negedge ref_clk);
        tx_valid = 1'b0;
    endtask
    task automatic rd_chk(input logic cd, input logic [7:0] e);
        i_pbus_host_model.xfer(cd, 1'b1, 1'b0, 8'h00, rdv, ok);
        `CHK(rdv, e)
        `CHK(ok, 1'b1)
    endtask
    initial
    begin
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (5) @(negedge ref_clk);
        `CHK(port_b_oe_n, 8'hFF)
        `CHK(port_a_oe_n, 8'hEF)
        `CHK(port_a_out, 8'h00)
        done("reset");
        for (int i = 0; i < 8; i++)
        begin
            nibble_mode = rows[i].nib;
            c0 = cmd_cnt;
            if (rows[i].rd && rows[i].cd) status_in = rows[i].v;
            if (rows[i].rd && !rows[i].cd) push(rows[i].v);
            i_pbus_host_model.xfer(rows[i].cd, rows[i].rd, rows[i].nib,
                rows[i].v, rdv, ok);
            if (rows[i].rd)
            begin
                `CHK(rdv, rows[i].v)
                `CHK(ok, 1'b1)
            end
            else if (rows[i].cd)
            begin
                `CHK(command_out, rows[i].v)
                `CHK(cmd_cnt, c0 + 1)
            end
            else
                `CHK(rx_got, rows[i].v)
        end
        nibble_mode = 1'b0;
        done("rows");
        c0 = cmd_cnt;
        i_pbus_host_model.raw(4'b0111, 20);
        `CHK(port_b_oe_n, 8'hFF)
        i_pbus_host_model.raw(4'b1011, 20);
        `CHK(port_b_oe_n, 8'hFF)
        i_pbus_host_model.raw(4'b0001, 20);
        `CHK(port_b_oe_n, 8'hFF)
        i_pbus_host_model.raw(4'b1111, 20);
        `CHK(cmd_cnt, c0)
        done("ignored strobes");
        // strobe far shorter than the data hold; data must outlast it
        i_pbus_host_model.raw(4'b1101, 10);
        i_pbus_host_model.raw(4'b1001, 0);
        n = 0;
        for (int k = 0; k < 40; k++)
        begin
            if (k == 3)
                i_pbus_host_model.raw(4'b1101, 0);
            @(negedge ref_clk);
            if (port_b_oe_n === 8'h00)
                n++;
        end
        i_pbus_host_model.raw(4'b1111, 10);
        `CHK(n >= 30, 1'b1)
        done("short strobe");
        n = 0;
        repeat (10)
        begin
            @(negedge ref_clk);
            if (tx_ready === 1'b1)
            begin
                tx_data = 8'h40 + 8'(n);
                tx_valid = 1'b1;
                n++;
            end
            @(negedge ref_clk);
            tx_valid = 1'b0;
        end
        `CHK(n, 8)
        for (int k = 0; k < 8; k++)
            rd_chk(1'b0, 8'h40 + 8'(k));
        done("fifo");
        @(negedge ref_clk);
        request_set = 1'b1;
        @(negedge ref_clk);
        request_set = 1'b0;
        status_in = 8'h81;
        `CHK(port_a_out[4], 1'b1)
        rd_chk(1'b0, 8'h00);
        `CHK(port_a_out[4], 1'b1)
        rd_chk(1'b1, 8'h81);
        `CHK(port_a_out[4], 1'b0)
        done("interrupt");
        wake_enable = 1'b1;
        standby_req = 1'b1;
        @(negedge ref_clk);
        standby_req = 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK(in_standby, 1'b1)
        keys[3] = 1'b1;
        repeat (10) @(negedge ref_clk);
        `CHK(woke, 1'b1)
        `CHK(in_standby, 1'b0)
        done("wakeup");
        port_path_data = 8'h6B;
        port_path_wr = 1'b1;
        @(negedge ref_clk);
        port_path_wr = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(port_read_data, 8'h6B)
        port_read_pins = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(port_read_data, {keys, 4'hF})
        done("port paths");
        stop_test();
    end
endmodule
